// [ris_irq.sv]
// rt1 interrupt sources: event detection, pending, log and irq
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "ris_cfg.svh"
module ris_irq import ris_pkg::*; #(
    parameter int LOG_DEPTH = `RIS_LOG_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [4:0] own_rt_addr,
    input wire ris_cmd_type cmd_in,
    input wire ris_msg_type msg_in,
    output ris_reply_type reply_out,
    output logic irq
);
    // software-visible state
    logic [7:0] enable;
    logic [7:0] pending;
    logic [1:0] config_bits;
    logic [31:0] illegal_tab [0:1];
    logic [31:0] access_tab [0:1];
    logic [7:0] index_cnt [0:31];
    logic [7:0] log_mem [0:LOG_DEPTH-1];
    logic [$clog2(LOG_DEPTH)-1:0] log_wr;
    logic [$clog2(LOG_DEPTH)-1:0] log_rd;
    ris_cmd_type last_cmd;
    logic [4:0] msg_idx;
    logic [7:0] events;
    logic [7:0] logged;
    logic [7:0] clear_mask;
    logic cmd_for_us;
    logic is_bcst;
    logic cmd_illegal;
    logic cmd_iwa;
    logic idx_hit;
    logic wr_en;
    logic rd_en;
    logic idx_wr;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign idx_wr = wr_en && paddr[11:7] == 5'h01;
    // counter slot of the finished message
    assign msg_idx = {msg_in.tr, msg_in.subaddr[3:0]};

    // address decode: broadcast only when enabled and not invalidated
    assign is_bcst = cmd_in.rt_addr == `RIS_BCST_ADDR && config_bits[`RIS_CFG_BCST_EN]
        && !config_bits[`RIS_CFG_BCST_INV];
    assign cmd_for_us = cmd_in.valid && (cmd_in.rt_addr == own_rt_addr || is_bcst)
        && !(cmd_in.rt_addr == `RIS_BCST_ADDR && config_bits[`RIS_CFG_BCST_INV]);
    // table lookup: tr selects the table word, subaddress the bit
    assign cmd_illegal = illegal_tab[cmd_in.tr][cmd_in.subaddr];
    assign cmd_iwa = access_tab[cmd_in.tr][cmd_in.subaddr];
    // indexed count reaching zero or circular quota done
    assign idx_hit = msg_in.done && !msg_in.msg_error
        && index_cnt[{msg_in.tr, msg_in.subaddr[3:0]}] == 8'h01;

    // event vector, low bits hard zero
    always_comb begin
        events = 8'h00;
        events[`RIS_BIT_IXZ] = idx_hit;
        events[`RIS_BIT_ILL] = cmd_for_us && cmd_illegal;
        events[`RIS_BIT_BCST] = cmd_for_us && is_bcst;
        events[`RIS_BIT_MERR] = msg_in.done && msg_in.msg_error;
        events[`RIS_BIT_IWA] = cmd_for_us && cmd_iwa;
        logged = events & enable & `RIS_EVT_MASK;
        clear_mask = (wr_en && paddr == `RIS_OFF_CLEAR) ? pwdata[7:0] : 8'h00;
    end

    // registers written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable <= `RIS_RST_ENABLE;
            config_bits <= `RIS_RST_CONFIG;
            illegal_tab[0] <= 32'h00000000;
            illegal_tab[1] <= 32'h00000000;
            access_tab[0] <= 32'h00000000;
            access_tab[1] <= 32'h00000000;
        end else if (wr_en) begin
            case (paddr)
                `RIS_OFF_ENABLE: enable <= pwdata[7:0] & `RIS_EVT_MASK;
                `RIS_OFF_CONFIG: config_bits <= pwdata[1:0];
                `RIS_OFF_ILLEGAL: illegal_tab[pwdata[31]] <= {1'b0, pwdata[30:0]};
                `RIS_OFF_ACCESS: access_tab[pwdata[31]] <= {1'b0, pwdata[30:0]};
                default: ;
            endcase
        end
    end

    // message index counters, loaded by software, counted per message
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 32; i++) begin
                index_cnt[i] <= 8'h00;
            end
        end else begin
            if (msg_in.done && !msg_in.msg_error
                && index_cnt[{msg_in.tr, msg_in.subaddr[3:0]}] != 8'h00) begin
                index_cnt[{msg_in.tr, msg_in.subaddr[3:0]}] <=
                    index_cnt[{msg_in.tr, msg_in.subaddr[3:0]}] - 8'h01;
            end
            if (idx_wr) begin
                index_cnt[paddr[6:2]] <= pwdata[7:0];
            end
        end
    end

    // sticky pending bits, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending <= 8'h00;
        end else begin
            pending <= ((pending & ~clear_mask) | logged) & `RIS_EVT_MASK;
        end
    end

    // interrupt log ring, newest entries overwrite oldest
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            log_wr <= '0;
        end else if (logged != 8'h00) begin
            log_mem[log_wr] <= logged;
            log_wr <= log_wr + 1'b1;
        end
    end

    // log read pointer advances on each log read while the log is not empty
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            log_rd <= '0;
        end else if (rd_en && paddr == `RIS_OFF_LOG && log_rd != log_wr) begin
            log_rd <= log_rd + 1'b1;
        end
    end

    // status-only reply with error flag for illegal commands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reply_out <= '0;
            last_cmd <= '0;
        end else begin
            reply_out.send <= cmd_for_us && !is_bcst;
            reply_out.msg_error <= cmd_for_us && cmd_illegal;
            reply_out.suppress_data <= cmd_for_us && cmd_illegal;
            if (cmd_for_us) begin
                last_cmd <= cmd_in;
            end
        end
    end

    // irq level follows enabled pending bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((pending & ~clear_mask) | logged) & enable);
        end
    end

    // apb read data and zero-wait answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                pslverr <= !(paddr <= `RIS_OFF_LAST_CMD || paddr[11:7] == 5'h01)
                    || paddr[1:0] != 2'h0;
                case (paddr)
                    `RIS_OFF_ENABLE: prdata <= {24'h000000, enable};
                    `RIS_OFF_PENDING: prdata <= {24'h000000, pending};
                    `RIS_OFF_CONFIG: prdata <= {30'h00000000, config_bits};
                    `RIS_OFF_LOG: prdata <= {24'h000000,
                        (log_rd != log_wr) ? log_mem[log_rd] : 8'h00};
                    `RIS_OFF_LAST_CMD: prdata <= {15'h0000, last_cmd};
                    default: prdata <= idx_wr_read(paddr);
                endcase
            end
        end
    end

    // index counter readback, zero elsewhere
    function automatic logic [31:0] idx_wr_read(input logic [11:0] a);
        logic [31:0] r;
        r = 32'h00000000;
        if (a[11:7] == 5'h01) begin
            r = {24'h000000, index_cnt[a[6:2]]};
        end
        return r;
    endfunction

    // checks: reserved bits
    chk_low_bits_zero: assert property (@(posedge pclk) disable iff (!presetn)
        pending[2:0] == 3'h0)
        else $error("reserved pending bits set");
    chk_enable_low: assert property (@(posedge pclk) disable iff (!presetn)
        enable[2:0] == 3'h0)
        else $error("reserved enable bits set");

    // checks: illegal command detection and reply
    chk_ill_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_for_us && cmd_illegal) |-> events[6])
        else $error("illegal missed");
    chk_ill_only: assert property (@(posedge pclk) disable iff (!presetn)
        events[6] |-> cmd_for_us && cmd_illegal)
        else $error("illegal event without illegal command");
    chk_ill_reply: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_for_us && cmd_illegal) |=> reply_out.msg_error && reply_out.suppress_data)
        else $error("illegal reply wrong");
    chk_legal_reply: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_for_us && !cmd_illegal) |=> !reply_out.msg_error && !reply_out.suppress_data)
        else $error("legal reply carries error");
    chk_disabled_ill: assert property (@(posedge pclk) disable iff (!presetn)
        (events[6] && !enable[6] && !pending[6] && clear_mask == 8'h00) |=> !pending[6])
        else $error("disabled illegal event changed pending");
    chk_ill_unlogged: assert property (@(posedge pclk) disable iff (!presetn)
        (events[6] && !enable[6]) |-> !logged[6])
        else $error("disabled illegal event logged");

    // checks: broadcast reception and invalidation
    chk_bcst_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_in.valid && cmd_in.rt_addr == 5'h1f && config_bits == 2'h1) |-> events[5])
        else $error("broadcast missed");
    chk_bcst_off: assert property (@(posedge pclk) disable iff (!presetn)
        !config_bits[0] |-> !events[5])
        else $error("broadcast event while not enabled");
    chk_bcst_noreply: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_for_us && is_bcst) |=> !reply_out.send)
        else $error("status sent for broadcast");
    chk_bcst_inv: assert property (@(posedge pclk) disable iff (!presetn)
        config_bits[1] |-> !events[5])
        else $error("broadcast event while invalid");
    chk_inv_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_in.rt_addr == 5'h1f && config_bits[1]) |-> !cmd_for_us)
        else $error("invalidated address accepted");

    // checks: message error and access notification
    chk_merr_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (msg_in.done && msg_in.msg_error) |-> events[4])
        else $error("merr missed");
    chk_merr_only: assert property (@(posedge pclk) disable iff (!presetn)
        events[4] |-> msg_in.done && msg_in.msg_error)
        else $error("merr event without error");
    chk_iwa_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_for_us && cmd_iwa) |-> events[3])
        else $error("iwa missed");
    chk_iwa_only: assert property (@(posedge pclk) disable iff (!presetn)
        events[3] |-> cmd_for_us && cmd_iwa)
        else $error("iwa event without option");

    // checks: index counters
    chk_idx_zero: assert property (@(posedge pclk) disable iff (!presetn)
        idx_hit && !idx_wr |=> index_cnt[$past(msg_idx)] == 8'h00)
        else $error("index not zero");
    chk_idx_count: assert property (@(posedge pclk) disable iff (!presetn)
        (msg_in.done && !msg_in.msg_error && index_cnt[msg_idx] != 8'h00 && !idx_wr)
        |=> index_cnt[$past(msg_idx)] == $past(index_cnt[msg_idx]) - 8'h01)
        else $error("index count not stepped");
    chk_idx_err_none: assert property (@(posedge pclk) disable iff (!presetn)
        (msg_in.done && msg_in.msg_error) |-> !events[7])
        else $error("index event on errored message");

    // checks: pending, irq and log
    chk_enabled_set: assert property (@(posedge pclk) disable iff (!presetn)
        (logged != 8'h00) |=> (pending & $past(logged)) == $past(logged) && irq)
        else $error("enabled event not pending");
    chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> irq == |(pending & $past(enable)))
        else $error("irq level wrong");
    chk_pend_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (pending & $past(pending & ~clear_mask)) == $past(pending & ~clear_mask))
        else $error("pending bit lost");
    chk_log_push: assert property (@(posedge pclk) disable iff (!presetn)
        (logged != 8'h00) |=> log_wr == $past(log_wr) + 1'b1)
        else $error("log entry not pushed");

    // checks: bus answer shape
    chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("pslverr without pready");
endmodule

// [ris_cfg.svh]
// offsets, bit positions, reset values and log depth for the rt1 interrupt block
`ifndef RIS_CFG_SVH
`define RIS_CFG_SVH
`define RIS_OFF_ENABLE 12'h000
`define RIS_OFF_PENDING 12'h004
`define RIS_OFF_CLEAR 12'h008
`define RIS_OFF_CONFIG 12'h00c
`define RIS_OFF_ILLEGAL 12'h010
`define RIS_OFF_ACCESS 12'h014
`define RIS_OFF_INDEX 12'h018
`define RIS_OFF_LOG 12'h01c
`define RIS_OFF_LAST_CMD 12'h020
`define RIS_BIT_IXZ 7
`define RIS_BIT_ILL 6
`define RIS_BIT_BCST 5
`define RIS_BIT_MERR 4
`define RIS_BIT_IWA 3
`define RIS_EVT_MASK 8'hf8
`define RIS_RST_ENABLE 8'h00
`define RIS_RST_CONFIG 2'h0
`define RIS_CFG_BCST_EN 0
`define RIS_CFG_BCST_INV 1
`define RIS_BCST_ADDR 5'h1f
`define RIS_LOG_DEPTH 32
`endif

// [ris_pkg.sv]
// types shared by the rt1 interrupt block
package ris_pkg;
    // one decoded command word from the protocol engine
    typedef struct packed {
        logic valid;
        logic [4:0] rt_addr;
        logic tr;
        logic [4:0] subaddr;
        logic [4:0] wc_mc;
    } ris_cmd_type;
    // per-message completion report
    typedef struct packed {
        logic done;
        logic msg_error;
        logic [4:0] subaddr;
        logic tr;
        logic circular;
    } ris_msg_type;
    // status reply request toward the encoder
    typedef struct packed {
        logic send;
        logic msg_error;
        logic suppress_data;
    } ris_reply_type;
endpackage

// [ris_bc_model.sv]
// bus controller stand-in: turns bench requests into command and message pulses
`timescale 1ns/1ps
module ris_bc_model import ris_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic send_cmd,
    input wire ris_cmd_type cmd_word,
    input wire logic send_msg,
    input wire ris_msg_type msg_word,
    output ris_cmd_type cmd_in,
    output ris_msg_type msg_in
);
    // one-cycle pulse per request, all zero between requests
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_in <= '0;
            msg_in <= '0;
        end else begin
            cmd_in <= send_cmd ? cmd_word : '0;
            msg_in <= send_msg ? msg_word : '0;
        end
    end
endmodule

// [ris_irq_test.sv]
// self-checking bench for the rt1 interrupt source block
`timescale 1ns/1ps
`include "ris_cfg.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module ris_irq_test import ris_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slv;
    logic send_cmd, send_msg;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [4:0] own_rt_addr, sa;
    ris_cmd_type cmd_in, cmd_word;
    ris_msg_type msg_in, msg_word;
    ris_reply_type reply_out, last_reply;
    int err_count = 0;
    int n_tests = 0;
    ris_irq dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .own_rt_addr(own_rt_addr),
        .cmd_in(cmd_in), .msg_in(msg_in), .reply_out(reply_out), .irq(irq));
    ris_bc_model bc (.pclk(pclk), .presetn(presetn), .send_cmd(send_cmd),
        .cmd_word(cmd_word), .send_msg(send_msg), .msg_word(msg_word),
        .cmd_in(cmd_in), .msg_in(msg_in));
    // clock and reply capture
    always #5 pclk = ~pclk;
    always @(posedge pclk) if (reply_out.send === 1'b1) last_reply <= reply_out;
    task automatic final_report();
        $display("compares %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one apb transfer, waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 50);
        rdat = prdata;
        slv = pslverr;
        if (pready !== 1'b1) begin err_count++; final_report(); end
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic fire(input logic is_cmd, input ris_cmd_type c, input ris_msg_type m);
        last_reply = '0;
        if (is_cmd) begin send_cmd <= 1'b1; cmd_word <= c; end
        else begin send_msg <= 1'b1; msg_word <= m; end
        @(posedge pclk);
        send_cmd <= 1'b0; send_msg <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
    // pending, irq and log must show bit b only when on, then clear
    task automatic chk_evt(input int b, input logic on);
        logic [31:0] e;
        e = on ? (32'h1 << b) : 32'h0;
        apb(1'b0, `RIS_OFF_PENDING, 32'h0);
        `CHK("pending", e, rdat)
        `CHK("irq", on, irq)
        apb(1'b0, `RIS_OFF_LOG, 32'h0);
        `CHK("log", e, rdat)
        apb(1'b1, `RIS_OFF_CLEAR, 32'hff);
        @(posedge pclk);
        `CHK("irq clear", 1'b0, irq)
        $display("test bit %0d on %0d done", b, on);
    endtask
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
        pwdata = '0; send_cmd = 0; send_msg = 0; cmd_word = '0; msg_word = '0;
        last_reply = '0;
        void'($urandom(59));
        own_rt_addr = 5'($urandom_range(30));
        sa = 5'($urandom_range(15, 1));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reserved low bits stay zero, nothing pending after reset
        apb(1'b1, `RIS_OFF_ENABLE, 32'hff);
        apb(1'b0, `RIS_OFF_ENABLE, 32'h0);
        `CHK("enable", 32'hf8, rdat)
        chk_evt(0, 1'b0);
        // illegal entry loaded only for the chosen subaddress
        apb(1'b1, `RIS_OFF_ILLEGAL, {1'b0, 31'(32'h1 << sa)});
        apb(1'b1, `RIS_OFF_ENABLE, 32'h40);
        fire(1'b1, '{1'b1, own_rt_addr, 1'b0, sa + 5'h1, 5'($urandom)}, '0);
        `CHK("legal reply", 3'b100, last_reply)
        chk_evt(6, 1'b0);
        fire(1'b1, '{1'b1, own_rt_addr, 1'b0, sa, 5'($urandom)}, '0);
        `CHK("illegal reply", 3'b111, last_reply)
        chk_evt(6, 1'b1);
        apb(1'b1, `RIS_OFF_ENABLE, 32'h08);
        fire(1'b1, '{1'b1, own_rt_addr, 1'b0, sa, 5'h3}, '0);
        chk_evt(6, 1'b0);
        // broadcast accepted, then invalidated
        apb(1'b1, `RIS_OFF_CONFIG, 32'h1);
        apb(1'b1, `RIS_OFF_ENABLE, 32'h20);
        fire(1'b1, '{1'b1, `RIS_BCST_ADDR, 1'b0, sa + 5'h2, 5'h2}, '0);
        chk_evt(5, 1'b1);
        apb(1'b1, `RIS_OFF_CONFIG, 32'h3);
        fire(1'b1, '{1'b1, `RIS_BCST_ADDR, 1'b0, sa + 5'h2, 5'h2}, '0);
        chk_evt(5, 1'b0);
        // message error status
        apb(1'b1, `RIS_OFF_ENABLE, 32'h10);
        fire(1'b0, '0, '{1'b1, 1'b1, sa, 1'b0, 1'b0});
        chk_evt(4, 1'b1);
        // access notification
        apb(1'b1, `RIS_OFF_ACCESS, {1'b0, 31'(32'h1 << sa)});
        apb(1'b1, `RIS_OFF_ENABLE, 32'h08);
        fire(1'b1, '{1'b1, own_rt_addr, 1'b0, sa, 5'h1}, '0);
        chk_evt(3, 1'b1);
        // circular quota of two, then indexed count from one
        apb(1'b1, `RIS_OFF_ENABLE, 32'h80);
        apb(1'b1, 12'h080 + 12'(sa[3:0]) * 12'h4, 32'h2);
        apb(1'b0, 12'h080 + 12'(sa[3:0]) * 12'h4, 32'h0);
        `CHK("index", 32'h2, rdat)
        fire(1'b0, '0, '{1'b1, 1'b0, sa, 1'b0, 1'b1});
        chk_evt(7, 1'b0);
        fire(1'b0, '0, '{1'b1, 1'b0, sa, 1'b0, 1'b1});
        chk_evt(7, 1'b1);
        apb(1'b1, 12'h080 + 12'(sa[3:0]) * 12'h4, 32'h1);
        fire(1'b0, '0, '{1'b1, 1'b0, sa, 1'b0, 1'b0});
        chk_evt(7, 1'b1);
        // unmapped address is refused
        apb(1'b0, 12'h044, 32'h0);
        `CHK("slverr", 1'b1, slv)
        final_report();
    end
endmodule
